// ==== output_skew_and_cal_gating.sv ====
// Output phase skew registers and clock output gating around calibration
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Each skew field is a signed 8-bit offset in high-speed divider clocks.
// - Fifth output skew applies only while clock configuration select is zero.
// - Reset loads output two skew with one, all others with zero.
// - Always-on and squelch clear: outputs off until first calibration ends.
// - Squelch set only: outputs off until a calibration succeeds and during every calibration; skew preserved.
// - Always-on set: outputs always run; skew preserved only with squelch.
// - Listed settings take effect only when a calibration runs.
// - Calibration start bit self-clears at completion, marked by loss of lock low after the minimum time or by the timeout.
module output_skew_and_cal_gating (
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // Configuration port
  input wire logic CFG_WR_I,
  input wire logic [7:0] CFG_ADDR_I,
  input wire logic [7:0] CFG_WDATA_I,
  output logic [7:0] CFG_RDATA_O,
  // Loose control bits
  input wire logic CALIBRATION_START_I,
  input wire logic SQUELCH_DURING_CALIBRATION_I,
  input wire logic [1:0] CLOCK_CONFIGURATION_SELECT_I,
  input wire skew_cal_pkg::cal_settings_t PENDING_SETTINGS_I,
  // Synthesizer side
  input wire logic LOSS_OF_LOCK_ALARM_I,
  input wire logic HS_DIV_TICK_I,
  // Results
  output var skew_cal_pkg::cal_settings_t APPLIED_SETTINGS_O,
  output logic CALIBRATION_START_O,
  output logic CLOCK_OUTPUTS_ENABLE_O,
  output logic SKEW_PRESERVED_O,
  output logic [4:0] PHASE_ADVANCE_O,
  output logic [4:0] PHASE_RETARD_O
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [1:0] lol_sync_reg;
  logic loss_of_lock_alarm;
  logic [7:0] skew_reg [5];
  logic signed [7:0] applied_reg [5];
  logic signed [7:0] target [5];
  skew_cal_pkg::cal_settings_t applied_settings_reg;
  skew_cal_pkg::cal_state_t cal_state_reg;
  logic [15:0] cal_cnt_reg;
  logic first_done_reg;
  logic first_ok_reg;
  logic cal_end;
  logic cal_ok;
  logic gate_next;
  logic [7:0] rdata_next;

  // Reset release
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Loss of lock comes from the analog loop
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      lol_sync_reg <= 2'b11;
    end else begin
      lol_sync_reg <= {lol_sync_reg[0], LOSS_OF_LOCK_ALARM_I};
    end
  end
  assign loss_of_lock_alarm = lol_sync_reg[1];

  // Skew registers
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      skew_reg[0] <= skew_cal_pkg::OUT1_SKEW_RESET;
      skew_reg[1] <= skew_cal_pkg::OUT2_SKEW_RESET;
      skew_reg[2] <= skew_cal_pkg::OUT3_SKEW_RESET;
      skew_reg[3] <= skew_cal_pkg::OUT4_SKEW_RESET;
      skew_reg[4] <= skew_cal_pkg::OUT5_SKEW_RESET;
    end else if (CFG_WR_I) begin
      case (CFG_ADDR_I)
        skew_cal_pkg::OUT1_SKEW_OFFSET: skew_reg[0] <= CFG_WDATA_I;
        skew_cal_pkg::OUT2_SKEW_OFFSET: skew_reg[1] <= CFG_WDATA_I;
        skew_cal_pkg::OUT3_SKEW_OFFSET: skew_reg[2] <= CFG_WDATA_I;
        skew_cal_pkg::OUT4_SKEW_OFFSET: skew_reg[3] <= CFG_WDATA_I;
        skew_cal_pkg::OUT5_SKEW_OFFSET: skew_reg[4] <= CFG_WDATA_I;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (CFG_ADDR_I)
      skew_cal_pkg::OUT1_SKEW_OFFSET: rdata_next = skew_reg[0];
      skew_cal_pkg::OUT2_SKEW_OFFSET: rdata_next = skew_reg[1];
      skew_cal_pkg::OUT3_SKEW_OFFSET: rdata_next = skew_reg[2];
      skew_cal_pkg::OUT4_SKEW_OFFSET: rdata_next = skew_reg[3];
      skew_cal_pkg::OUT5_SKEW_OFFSET: rdata_next = skew_reg[4];
      default: rdata_next = skew_cal_pkg::UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CFG_RDATA_O <= 8'h00;
    end else begin
      CFG_RDATA_O <= rdata_next;
    end
  end

  // Phase steppers, one divider clock per tick toward the target
  for (genvar i = 0; i < 5; i++) begin : g_out
    if (i == 4) begin : g_cfg
      assign target[i] = (CLOCK_CONFIGURATION_SELECT_I == skew_cal_pkg::CLOCK_CONFIG_SKEW5) ?
                         $signed(skew_reg[i]) : 8'sh00;
    end else begin : g_plain
      assign target[i] = $signed(skew_reg[i]);
    end
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
      if (!rst_n) begin
        applied_reg[i] <= 8'sh00;
        PHASE_ADVANCE_O[i] <= 1'b0;
        PHASE_RETARD_O[i] <= 1'b0;
      end else begin
        PHASE_ADVANCE_O[i] <= 1'b0;
        PHASE_RETARD_O[i] <= 1'b0;
        if (HS_DIV_TICK_I && (target[i] > applied_reg[i])) begin
          applied_reg[i] <= applied_reg[i] + 8'sh01;
          PHASE_ADVANCE_O[i] <= 1'b1;
        end else if (HS_DIV_TICK_I && (target[i] < applied_reg[i])) begin
          applied_reg[i] <= applied_reg[i] - 8'sh01;
          PHASE_RETARD_O[i] <= 1'b1;
        end
      end
    end
  end

  // Calibration sequencer
  assign cal_ok = (cal_state_reg == skew_cal_pkg::CAL_RUN) && !loss_of_lock_alarm &&
                  (cal_cnt_reg >= 16'(skew_cal_pkg::CAL_MIN_CYCLES));
  assign cal_end = cal_ok || ((cal_state_reg == skew_cal_pkg::CAL_RUN) &&
                   (cal_cnt_reg >= 16'(skew_cal_pkg::CAL_TIMEOUT_CYCLES)));

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= skew_cal_pkg::CAL_IDLE;
      cal_cnt_reg <= 16'h0000;
      applied_settings_reg <= '0;
    end else begin
      case (cal_state_reg)
        skew_cal_pkg::CAL_IDLE: begin
          cal_cnt_reg <= 16'h0000;
          if (CALIBRATION_START_I) begin
            cal_state_reg <= skew_cal_pkg::CAL_RUN;
            applied_settings_reg <= PENDING_SETTINGS_I;
          end
        end
        skew_cal_pkg::CAL_RUN: begin
          cal_cnt_reg <= cal_cnt_reg + 16'h0001;
          if (cal_end) begin
            cal_state_reg <= skew_cal_pkg::CAL_IDLE;
          end
        end
        default: cal_state_reg <= skew_cal_pkg::CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      first_done_reg <= 1'b0;
      first_ok_reg <= 1'b0;
    end else begin
      if (cal_end) begin
        first_done_reg <= 1'b1;
      end
      if (cal_ok) begin
        first_ok_reg <= 1'b1;
      end
    end
  end

  // Output gating
  always_comb begin
    if (applied_settings_reg.outputs_always_running) begin
      gate_next = 1'b1;
    end else if (SQUELCH_DURING_CALIBRATION_I) begin
      gate_next = first_ok_reg && (cal_state_reg == skew_cal_pkg::CAL_IDLE);
    end else begin
      gate_next = first_done_reg;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CLOCK_OUTPUTS_ENABLE_O <= 1'b0;
      SKEW_PRESERVED_O <= 1'b0;
      CALIBRATION_START_O <= 1'b0;
      APPLIED_SETTINGS_O <= '0;
    end else begin
      CLOCK_OUTPUTS_ENABLE_O <= gate_next;
      SKEW_PRESERVED_O <= SQUELCH_DURING_CALIBRATION_I;
      CALIBRATION_START_O <= (cal_state_reg == skew_cal_pkg::CAL_RUN) && !cal_end;
      APPLIED_SETTINGS_O <= applied_settings_reg;
    end
  end

  // Checks
  property p_reset_skew;
    @(posedge SYS_CLK_I) $rose(rst_n) |-> (skew_reg[1] == 8'h01) && (skew_reg[0] == 8'h00);
  endproperty
  a_reset_skew: assert property (p_reset_skew) else $error("Skew reset values wrong");
  property p_adv_dir;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      PHASE_ADVANCE_O[0] |-> $past(target[0]) > $past(applied_reg[0]);
  endproperty
  a_adv_dir: assert property (p_adv_dir) else $error("Advance without positive error");
  property p_out5_cfg;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      (CLOCK_CONFIGURATION_SELECT_I != 2'h0) [*8] |-> ##1 !PHASE_ADVANCE_O[4] || applied_reg[4] <= 8'sh00;
  endproperty
  a_out5_cfg: assert property (p_out5_cfg) else $error("Fifth skew applied off config zero");
  property p_off_first;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      !first_done_reg && !applied_settings_reg.outputs_always_running |-> ##1 !CLOCK_OUTPUTS_ENABLE_O;
  endproperty
  a_off_first: assert property (p_off_first) else $error("Outputs on before first calibration");
  property p_squelch;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      (cal_state_reg == skew_cal_pkg::CAL_RUN) && SQUELCH_DURING_CALIBRATION_I &&
      !applied_settings_reg.outputs_always_running |-> ##1 !CLOCK_OUTPUTS_ENABLE_O;
  endproperty
  a_squelch: assert property (p_squelch) else $error("Outputs on while squelched");
  property p_always_on;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      applied_settings_reg.outputs_always_running |-> ##1 CLOCK_OUTPUTS_ENABLE_O;
  endproperty
  a_always_on: assert property (p_always_on) else $error("Always-on outputs stopped");
  property p_settings_hold;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      $changed(applied_settings_reg) |-> $past(CALIBRATION_START_I) && $past(cal_state_reg) == skew_cal_pkg::CAL_IDLE;
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("Settings changed without calibration");
  property p_cal_bounded;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      $rose(CALIBRATION_START_O) |-> ##[1:805] !CALIBRATION_START_O;
  endproperty
  a_cal_bounded: assert property (p_cal_bounded) else $error("Calibration bit never cleared");
  property p_step_tick;
    @(posedge SYS_CLK_I) disable iff (!rst_n)
      $changed(applied_reg[2]) |-> $past(HS_DIV_TICK_I) && (PHASE_ADVANCE_O[2] || PHASE_RETARD_O[2]);
  endproperty
  a_step_tick: assert property (p_step_tick) else $error("Phase moved off tick");
  c_cal_ok: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) cal_ok);
  c_cal_timeout: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) cal_end && !cal_ok);
  c_retard: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) PHASE_RETARD_O[1]);
  c_out_on: cover property (@(posedge SYS_CLK_I) disable iff (!rst_n) $rose(CLOCK_OUTPUTS_ENABLE_O));
endmodule

`default_nettype wire

// ==== skew_cal_pkg.sv ====
// Constants and types for output skew and calibration gating
package skew_cal_pkg;
  localparam int unsigned NUM_OUTPUTS = 5;
  localparam logic [7:0] OUT1_SKEW_OFFSET = 8'h8c;
  localparam logic [7:0] OUT2_SKEW_OFFSET = 8'h8d;
  localparam logic [7:0] OUT3_SKEW_OFFSET = 8'h8e;
  localparam logic [7:0] OUT4_SKEW_OFFSET = 8'h8f;
  localparam logic [7:0] OUT5_SKEW_OFFSET = 8'h90;
  localparam logic [7:0] OUT1_SKEW_RESET = 8'h00;
  localparam logic [7:0] OUT2_SKEW_RESET = 8'h01;
  localparam logic [7:0] OUT3_SKEW_RESET = 8'h00;
  localparam logic [7:0] OUT4_SKEW_RESET = 8'h00;
  localparam logic [7:0] OUT5_SKEW_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CAL_MIN_NS = 1000;
  localparam int unsigned CAL_TIMEOUT_NS = 40000;
  localparam int unsigned CAL_MIN_CYCLES = (CAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CAL_TIMEOUT_CYCLES = CAL_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] CLOCK_CONFIG_SKEW5 = 2'h0;

  // Settings that only take effect at a calibration start
  typedef struct packed {
    logic bypass;
    logic outputs_always_running;
    logic [7:0] input_priority_setting;
    logic [3:0] loop_bandwidth_select;
    logic [4:0] history_delay;
    logic [4:0] history_averaging;
    logic [4:0] output_disable;
    logic [1:0] input_power_down;
    logic [1:0] freq_offset_threshold;
    logic [2:0] lock_time_setting;
    logic [2:0] high_speed_divider;
    logic [19:0] output_low_speed_divider;
    logic [19:0] feedback_high_speed_divider;
    logic [18:0] input_predivider;
    logic [3:0] input_rate_range;
  } cal_settings_t;

  typedef enum logic [0:0] {
    CAL_IDLE = 1'b0,
    CAL_RUN = 1'b1
  } cal_state_t;
endpackage

// ==== tb_top.sv ====
// Self-checking bench for output skew registers and calibration gating
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk, reset_n, cfg_wr, cal_start, squelch, loss_of_lock_alarm, hs_tick;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
  logic [1:0] cfg_sel;
  skew_cal_pkg::cal_settings_t pend, applied;
  logic cal_busy, out_en, skew_keep;
  logic [4:0] adv, ret;
  logic [7:0] adv_cnt [5] = '{default: 8'h00};
  logic [7:0] ret_cnt [5] = '{default: 8'h00};
  int err_count, num_checks;
  int cycles = 0;
  logic [7:0] offs [5];
  logic [7:0] rstv [5];

  output_skew_and_cal_gating DUT (.SYS_CLK_I(sys_clk), .RESET_N_I(reset_n), .CFG_WR_I(cfg_wr),
    .CFG_ADDR_I(cfg_addr), .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
    .CALIBRATION_START_I(cal_start), .SQUELCH_DURING_CALIBRATION_I(squelch),
    .CLOCK_CONFIGURATION_SELECT_I(cfg_sel), .PENDING_SETTINGS_I(pend), .LOSS_OF_LOCK_ALARM_I(loss_of_lock_alarm),
    .HS_DIV_TICK_I(hs_tick), .APPLIED_SETTINGS_O(applied), .CALIBRATION_START_O(cal_busy),
    .CLOCK_OUTPUTS_ENABLE_O(out_en), .SKEW_PRESERVED_O(skew_keep), .PHASE_ADVANCE_O(adv),
    .PHASE_RETARD_O(ret));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Pulse counters and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
    for (int i = 0; i < 5; i++) begin
      adv_cnt[i] <= adv_cnt[i] + {7'h00, adv[i]};
      ret_cnt[i] <= ret_cnt[i] + {7'h00, ret[i]};
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    cfg_addr <= a;
    repeat (2) @(posedge sys_clk);
    #1 chk("rdata", exp, cfg_rdata);
  endtask

  // Runs ticks and checks pulse counts of one output
  task automatic steps(input int idx, input int n, input logic [7:0] ea, input logic [7:0] er);
    logic [7:0] a0;
    logic [7:0] r0;
    a0 = adv_cnt[idx];
    r0 = ret_cnt[idx];
    repeat (n) begin
      @(posedge sys_clk);
      hs_tick <= 1'b1;
      @(posedge sys_clk);
      hs_tick <= 1'b0;
      @(posedge sys_clk);
    end
    repeat (3) @(posedge sys_clk);
    #1 chk("advance", ea, adv_cnt[idx] - a0);
    chk("retard", er, ret_cnt[idx] - r0);
  endtask

  task automatic cal(input logic en_mid);
    int n;
    @(posedge sys_clk);
    loss_of_lock_alarm <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cal_start <= 1'b1;
    @(posedge sys_clk);
    cal_start <= 1'b0;
    repeat (10) @(posedge sys_clk);
    #1 chk("cal_busy", 8'h01, {7'h00, cal_busy});
    chk("out_en_mid", {7'h00, en_mid}, {7'h00, out_en});
    @(posedge sys_clk);
    loss_of_lock_alarm <= 1'b0;
    n = 0;
    while (cal_busy !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk("cal_done", 8'h00, {7'h00, cal_busy});
    repeat (3) @(posedge sys_clk);
    #1 chk("out_en_after", 8'h01, {7'h00, out_en});
    chk("skew_keep", {7'h00, squelch}, {7'h00, skew_keep});
    num_checks++;
    if (applied !== pend) begin
      err_count++;
      $display("[ERR] applied expected %h seen %h", pend, applied);
    end
  endtask

  initial begin
    offs = '{skew_cal_pkg::OUT1_SKEW_OFFSET, skew_cal_pkg::OUT2_SKEW_OFFSET, skew_cal_pkg::OUT3_SKEW_OFFSET,
      skew_cal_pkg::OUT4_SKEW_OFFSET, skew_cal_pkg::OUT5_SKEW_OFFSET};
    rstv = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    {reset_n, cfg_wr, cal_start, squelch, hs_tick} = '0;
    {cfg_addr, cfg_wdata, cfg_sel, err_count, num_checks} = '0;
    loss_of_lock_alarm = 1'b1;
    pend = '0;
    pend.high_speed_divider = 3'h5;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 5; i++) rd(offs[i], rstv[i]);
    steps(1, 2, 8'h01, 8'h00);
    wr(8'h8b, 8'h5a);
    rd(8'h8b, skew_cal_pkg::UNMAPPED_READ);
    for (int i = 0; i < 5; i++) wr(offs[i], 8'ha0 + 8'(i));
    for (int i = 0; i < 5; i++) rd(offs[i], 8'ha0 + 8'(i));
    for (int i = 0; i < 5; i++) wr(offs[i], 8'h00);
    repeat (20) @(posedge sys_clk);
    #1 chk("out_en_pre", 8'h00, {7'h00, out_en});
    chk("applied_pre", 8'h00, {5'h00, applied.high_speed_divider});
    cal(1'b0);
    cfg_sel <= 2'h1;
    wr(skew_cal_pkg::OUT1_SKEW_OFFSET, 8'h02);
    steps(0, 3, 8'h02, 8'h00);
    wr(skew_cal_pkg::OUT1_SKEW_OFFSET, 8'hff);
    steps(0, 4, 8'h00, 8'h03);
    steps(2, 2, 8'h00, 8'h00);
    steps(3, 2, 8'h00, 8'h00);
    wr(skew_cal_pkg::OUT5_SKEW_OFFSET, 8'h03);
    steps(4, 4, 8'h00, 8'h00);
    cfg_sel <= 2'h0;
    steps(4, 4, 8'h03, 8'h00);
    cfg_sel <= 2'h2;
    steps(4, 4, 8'h00, 8'h03);
    squelch <= 1'b1;
    cal(1'b0);
    pend.outputs_always_running <= 1'b1;
    pend.loop_bandwidth_select <= 4'h9;
    squelch <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("applied_hold", 8'h00, {4'h0, applied.loop_bandwidth_select});
    cal(1'b1);
    cal(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
